// File: boundary_scan_tap.sv
`timescale 1ns/100ps
module boundary_scan_tap #(
   parameter logic [3:0] ID_VERSION = 4'h1,    // arbitrary value
   parameter logic [15:0] ID_DEVICE = 16'h0001, // arbitrary value
   parameter logic [10:0] ID_MAKER = 11'h001    // arbitrary value
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // test port
   input wire bscan_pkg::tap_pins_t tap_i,
   output logic tdo_o,
   output logic tdo_oe_o,
   // pad and core side
   input wire logic [bscan_pkg::N_POS-1:0] pin_in_i,
   input wire logic [bscan_pkg::N_POS-1:0] core_out_i,
   input wire logic [bscan_pkg::N_POS-1:0] core_oe_i,
   output bscan_pkg::pad_drive_t pad_o,
   output logic [bscan_pkg::N_POS-1:0] core_in_o
);
   import bscan_pkg::*;

   // =====================================================
   // pin synchronisers
   tap_pins_t s1, s2, s3, lvl, next_lvl;

   // a change counts once the second and third stages agree
   always_comb
   begin
      next_lvl = lvl;
      for (int b = 0; b < 4; b++)
         if (s2[b] == s3[b])
            next_lvl[b] = s3[b];
   end

   logic rise, fall;
   assign rise = next_lvl.tck & ~lvl.tck;
   assign fall = ~next_lvl.tck & lvl.tck;

   // =====================================================
   // tap state and scan registers
   tap_state_t state, next_state;
   logic [IR_W-1:0] ir_sr, next_ir_sr, ir, next_ir;
   logic [N_CELL-1:0] dr_sr, next_dr_sr, upd, next_upd, cap;
   logic [ID_W-1:0] id_sr, next_id_sr;
   logic byp, next_byp, next_tdo, next_tdo_oe, bscan_sel, from_scan;
   instr_t instr;

   always_comb
   begin
      case (ir)
         IR_EXTEST: instr = I_EXTEST;
         IR_INTEST: instr = I_INTEST;
         IR_SAMPLE: instr = I_SAMPLE;
         IR_IDCODE: instr = I_IDCODE;
         IR_CLAMP: instr = I_CLAMP;
         IR_HIGHZ: instr = I_HIGHZ;
         default: instr = I_BYPASS;
      endcase
   end
   assign bscan_sel = (instr == I_EXTEST) | (instr == I_INTEST) | (instr == I_SAMPLE);

   for (genvar p = 0; p < N_POS; p++)
   begin : g_cell
      localparam int HI = cell_hi(p);
      assign cap[HI] = pin_in_i[p];
      if (IO_MAP[p])
      begin : g_io
         assign cap[HI-1] = core_out_i[p];
         assign cap[HI-2] = core_oe_i[p];
      end
   end

   function automatic tap_state_t tap_step(input tap_state_t s, input logic m);
      case (s)
         S_TLR: tap_step = m ? S_TLR : S_RTI;
         S_RTI: tap_step = m ? S_SDRS : S_RTI;
         S_SDRS: tap_step = m ? S_SIRS : S_CDR;
         S_CDR: tap_step = m ? S_E1DR : S_SDR;
         S_SDR: tap_step = m ? S_E1DR : S_SDR;
         S_E1DR: tap_step = m ? S_UDR : S_PDR;
         S_PDR: tap_step = m ? S_E2DR : S_PDR;
         S_E2DR: tap_step = m ? S_UDR : S_SDR;
         S_UDR: tap_step = m ? S_SDRS : S_RTI;
         S_SIRS: tap_step = m ? S_TLR : S_CIR;
         S_CIR: tap_step = m ? S_E1IR : S_SIR;
         S_SIR: tap_step = m ? S_E1IR : S_SIR;
         S_E1IR: tap_step = m ? S_UIR : S_PIR;
         S_PIR: tap_step = m ? S_E2IR : S_PIR;
         S_E2IR: tap_step = m ? S_UIR : S_SIR;
         S_UIR: tap_step = m ? S_SDRS : S_RTI;
         default: tap_step = S_TLR;
      endcase
   endfunction : tap_step

   always_comb
   begin
      next_state = state;
      next_ir_sr = ir_sr;
      next_ir = ir;
      next_dr_sr = dr_sr;
      next_upd = upd;
      next_id_sr = id_sr;
      next_byp = byp;
      next_tdo = tdo_o;
      next_tdo_oe = tdo_oe_o;
      if (rise)
      begin
         next_state = tap_step(state, next_lvl.tms);
         case (state)
            S_CIR: next_ir_sr = IR_CAPTURE;
            S_SIR: next_ir_sr = {next_lvl.tdi, ir_sr[IR_W-1:1]};
            S_CDR:
            begin
               if (bscan_sel)
                  next_dr_sr = cap;
               next_id_sr = {ID_VERSION, ID_DEVICE, ID_MAKER, 1'b1};
               next_byp = 1'b0;
            end
            S_SDR:
            begin
               if (bscan_sel)
                  next_dr_sr = {next_lvl.tdi, dr_sr[N_CELL-1:1]};
               if (instr == I_IDCODE)
                  next_id_sr = {next_lvl.tdi, id_sr[ID_W-1:1]};
               next_byp = next_lvl.tdi;
            end
            default: ;
         endcase
      end
      if (fall)
      begin
         next_tdo_oe = (state == S_SDR) | (state == S_SIR);
         next_tdo = (state == S_SIR) ? ir_sr[0] : bscan_sel ? dr_sr[0] :
                    (instr == I_IDCODE) ? id_sr[0] : byp;
         if (state == S_UIR)
            next_ir = ir_sr;
         if (state == S_UDR && bscan_sel)
            next_upd = dr_sr;
      end
      if (!next_lvl.trst_n)
         next_state = S_TLR;
      if (next_state == S_TLR)
      begin
         next_ir = IR_IDCODE;
         next_tdo_oe = 1'b0;
      end
   end

   // =====================================================
   // pad and core muxing
   // registered outputs cost one clock of latency on the functional path
   pad_drive_t next_pad;
   logic [N_POS-1:0] next_core_in;

   assign from_scan = (instr == I_EXTEST) | (instr == I_INTEST) | (instr == I_CLAMP);
   for (genvar p = 0; p < N_POS; p++)
   begin : g_mux
      localparam int HI = cell_hi(p);
      assign next_core_in[p] = (instr == I_INTEST) ? upd[HI] : pin_in_i[p];
      if (IO_MAP[p])
      begin : g_drv
         assign next_pad.out[p] = from_scan ? upd[HI-1] : core_out_i[p];
         assign next_pad.oe[p] = (instr == I_HIGHZ) ? 1'b0 :
                                 from_scan ? upd[HI-2] : core_oe_i[p];
      end
      else
      begin : g_in
         assign next_pad.out[p] = 1'b0;
         assign next_pad.oe[p] = 1'b0;
      end
   end

   // undriven pins read one; tck resets low so reset makes no false edge
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         s1 <= {1'b0, {3{SYNC_RST}}};
         s2 <= {1'b0, {3{SYNC_RST}}};
         s3 <= {1'b0, {3{SYNC_RST}}};
         lvl <= {1'b0, {3{SYNC_RST}}};
         state <= S_TLR;
         ir_sr <= IR_CAPTURE;
         ir <= IR_IDCODE;
         dr_sr <= '0;
         upd <= '0;
         id_sr <= '0;
         byp <= 1'b0;
         tdo_o <= 1'b0;
         tdo_oe_o <= 1'b0;
         pad_o <= '0;
         core_in_o <= '0;
      end
      else
      begin
         s1 <= tap_i;
         s2 <= s1;
         s3 <= s2;
         lvl <= next_lvl;
         state <= next_state;
         ir_sr <= next_ir_sr;
         ir <= next_ir;
         dr_sr <= next_dr_sr;
         upd <= next_upd;
         id_sr <= next_id_sr;
         byp <= next_byp;
         tdo_o <= next_tdo;
         tdo_oe_o <= next_tdo_oe;
         pad_o <= next_pad;
         core_in_o <= next_core_in;
      end
   end

   // =====================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   localparam int P1_OUT = cell_hi(1) - 1;
   localparam int P0_IN = cell_hi(0);
   sequence upd_fall_s;
      fall && state == S_UDR;
   endsequence
   sequence byp_shift_s;
      rise && state == S_SDR && instr == I_BYPASS;
   endsequence

   AST_TAP_STEP: assert property (rise && lvl.trst_n && next_lvl.trst_n && state == S_TLR
      && !next_lvl.tms |=> state == S_RTI)
      else $error("tap did not leave reset on tms low");
   AST_TRST: assert property (!lvl.trst_n |-> state == S_TLR)
      else $error("tap not in reset while test reset low");
   AST_IR_RESET: assert property (state == S_TLR |-> ir == IR_IDCODE)
      else $error("reset state without id instruction");
   AST_DECODE: assert property (ir == IR_HIGHZ |-> instr == I_HIGHZ)
      else $error("highz code misdecoded");
   AST_UNKNOWN: assert property (ir > IR_HIGHZ && ir != IR_BYPASS |-> instr == I_BYPASS)
      else $error("unknown code not bypass");
   AST_EXTEST: assert property (instr == I_EXTEST |=> pad_o.out[1] == $past(upd[P1_OUT]))
      else $error("extest pad not from update cell");
   AST_EXT_UPD: assert property (upd_fall_s and (instr == I_EXTEST) |=> upd == $past(dr_sr))
      else $error("update cells not loaded");
   AST_INTEST: assert property (instr == I_INTEST |=> core_in_o[0] == $past(upd[P0_IN]))
      else $error("intest core input not from update cell");
   AST_SAMPLE: assert property (instr == I_SAMPLE |=> pad_o.out[1] == $past(core_out_i[1]))
      else $error("sample disturbed functional output");
   AST_ID_LSB: assert property (rise && state == S_CDR && instr == I_IDCODE
      |=> id_sr[0] && id_sr[ID_DEV_LSB +: 16] == ID_DEVICE)
      else $error("id capture wrong");
   AST_CLAMP: assert property (rise && state == S_SDR && instr == I_CLAMP |=> $stable(dr_sr))
      else $error("clamp moved the scan register");
   AST_HIGHZ: assert property (instr == I_HIGHZ |=> pad_o.oe == '0)
      else $error("highz left an output driven");
   AST_BYPASS: assert property (byp_shift_s |=> byp == $past(next_lvl.tdi))
      else $error("bypass stage did not take data-in");
   AST_TDO_IDLE: assert property (fall && state != S_SDR && state != S_SIR |=> !tdo_oe_o)
      else $error("data-out driven outside shift");
   AST_TDO_HOLD: assert property (!fall |=> $stable(tdo_o))
      else $error("data-out changed off the falling edge");

endmodule : boundary_scan_tap

// File: bscan_pkg.sv
package bscan_pkg;

   // =====================================================
   // chain shape
   localparam int N_POS = 47;
   localparam int N_CELL = 99;
   localparam int IR_W = 4;
   localparam int ID_W = 32;
   // bit p set: chain position p (0 = data-in end) is a two-way pin
   localparam logic [N_POS-1:0] IO_MAP = 47'h002fc3bfeee2;

   // =====================================================
   // instruction codes
   localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
   localparam logic [IR_W-1:0] IR_INTEST = 4'h1;
   localparam logic [IR_W-1:0] IR_SAMPLE = 4'h2;
   localparam logic [IR_W-1:0] IR_IDCODE = 4'h3;
   localparam logic [IR_W-1:0] IR_CLAMP = 4'h4;
   localparam logic [IR_W-1:0] IR_HIGHZ = 4'h5;
   localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
   localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

   // =====================================================
   // identification layout and reset values
   localparam int ID_VER_LSB = 28;
   localparam int ID_DEV_LSB = 12;
   localparam int ID_MFR_LSB = 1;
   localparam logic SYNC_RST = 1'h1;

   // =====================================================
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int TCK_PERIOD_NS = 160;
   localparam int TCK_CYCLES = TCK_PERIOD_NS / CLK_PERIOD_NS;

   // =====================================================
   // types
   typedef enum logic [15:0] {
      S_TLR = 16'h0001, S_RTI = 16'h0002, S_SDRS = 16'h0004, S_CDR = 16'h0008,
      S_SDR = 16'h0010, S_E1DR = 16'h0020, S_PDR = 16'h0040, S_E2DR = 16'h0080,
      S_UDR = 16'h0100, S_SIRS = 16'h0200, S_CIR = 16'h0400, S_SIR = 16'h0800,
      S_E1IR = 16'h1000, S_PIR = 16'h2000, S_E2IR = 16'h4000, S_UIR = 16'h8000
   } tap_state_t;

   typedef enum logic [6:0] {
      I_EXTEST = 7'h01, I_INTEST = 7'h02, I_SAMPLE = 7'h04, I_IDCODE = 7'h08,
      I_CLAMP = 7'h10, I_HIGHZ = 7'h20, I_BYPASS = 7'h40
   } instr_t;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
   } tap_pins_t;

   typedef struct packed {
      logic [N_POS-1:0] out;
      logic [N_POS-1:0] oe;
   } pad_drive_t;

   // highest cell index of chain position p
   function automatic int cell_hi(input int p);
      int b;
      b = 0;
      for (int j = 0; j < p; j++)
         b = b + (IO_MAP[j] ? 3 : 1);
      return N_CELL - 1 - b;
   endfunction : cell_hi

endpackage : bscan_pkg

// File: tap_tester.sv
`timescale 1ns/100ps
module tap_tester (
   // clock
   input wire logic clk_i,
   // test port, tester side
   output bscan_pkg::tap_pins_t tap_o,
   input wire logic tdo_i,
   input wire logic tdo_oe_i
);
   import bscan_pkg::*;

   // =====================================================
   // idle levels
   // undriven lines read one
   initial tap_o = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};

   // =====================================================
   // one test clock period
   // 160 ns period
   task automatic step(input logic tms, input logic tdi, output logic to, output logic oe);
      tap_o.tms <= tms;
      tap_o.tdi <= tdi;
      repeat (8) @(posedge clk_i);
      // tdo launched at the previous fall, taken just before this rise
      to = tdo_i;
      oe = tdo_oe_i;
      tap_o.tck <= 1'b1;
      repeat (8) @(posedge clk_i);
      tap_o.tck <= 1'b0;
   endtask : step

   task automatic reset_tap();
      tap_o.trst_n <= 1'b0;
      repeat (10) @(posedge clk_i);
      tap_o.trst_n <= 1'b1;
      repeat (10) @(posedge clk_i);
   endtask : reset_tap

   // =====================================================
   // full scan from idle back to idle, lsb first
   // standard state walk
   task automatic scan(input logic ir, input int n, input logic [N_CELL-1:0] din,
                       output logic [N_CELL-1:0] dout, output logic oe_all);
      logic to;
      logic oe;
      dout = '0;
      oe_all = 1'b1;
      step(1'b0, 1'b1, to, oe);
      step(1'b1, 1'b1, to, oe);
      if (ir)
         step(1'b1, 1'b1, to, oe);
      step(1'b0, 1'b1, to, oe);
      step(1'b0, 1'b1, to, oe);
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], to, oe);
         dout[i] = to;
         oe_all = oe_all & oe;
      end
      step(1'b1, 1'b1, to, oe);
      step(1'b0, 1'b1, to, oe);
      // tck stands low between frames; let pad registers settle
      repeat (8) @(posedge clk_i);
   endtask : scan

endmodule : tap_tester

// File: boundary_scan_tap_tb.sv
`timescale 1ns/100ps
module boundary_scan_tap_tb;
   import bscan_pkg::*;

   // =====================================================
   // signals
   logic clk;
   logic arst_n;
   tap_pins_t tap;
   logic tdo;
   logic tdo_oe;
   logic [N_POS-1:0] pin_in;
   logic [N_POS-1:0] core_out;
   logic [N_POS-1:0] core_oe;
   logic [N_POS-1:0] core_in;
   pad_drive_t pad;
   int error_cnt = 0;
   int tests_run = 0;
   int hi [N_POS];
   logic [N_CELL-1:0] pv;
   logic [N_CELL-1:0] got;
   logic [N_CELL-1:0] exp;
   logic oe_all;
   // id fields are arbitrary values
   localparam logic [31:0] ID_EXP = {4'ha, 16'h5c3e, 11'h2b7, 1'b1};

   boundary_scan_tap #(.ID_VERSION(4'ha), .ID_DEVICE(16'h5c3e), .ID_MAKER(11'h2b7))
      u_boundary_scan_tap (.clk_i(clk), .arst_n_i(arst_n), .tap_i(tap), .tdo_o(tdo),
      .tdo_oe_o(tdo_oe), .pin_in_i(pin_in), .core_out_i(core_out), .core_oe_i(core_oe),
      .pad_o(pad), .core_in_o(core_in));

   tap_tester u_tap_tester (.clk_i(clk), .tap_o(tap), .tdo_i(tdo), .tdo_oe_i(tdo_oe));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // =====================================================
   // helpers
   task automatic chk(input logic [N_CELL-1:0] g, input logic [N_CELL-1:0] e, input string m);
      tests_run++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value at %0t ns: %s", $time, m);
      end
   endtask : chk

   task automatic conclude();
      $display("checks %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude

   function automatic pad_drive_t pad_of(input logic [N_CELL-1:0] v);
      pad_drive_t r;
      r = '0;
      for (int p = 0; p < N_POS; p++)
         if (IO_MAP[p])
         begin
            r.out[p] = v[hi[p]-1];
            r.oe[p] = v[hi[p]-2];
         end
      return r;
   endfunction : pad_of

   task automatic ir(input logic [3:0] c);
      u_tap_tester.scan(1'b1, 4, N_CELL'(c), got, oe_all);
      chk(N_CELL'(got[3:0]), N_CELL'(4'h1), "ir capture");
   endtask : ir

   // =====================================================
   // scenarios
   task automatic t_idcode();
      u_tap_tester.reset_tap();
      u_tap_tester.scan(1'b0, 32, '1, got, oe_all);
      chk(N_CELL'(got[31:0]), N_CELL'(ID_EXP), "id read");
      chk(N_CELL'(oe_all), N_CELL'(1'b1), "tdo enable in shift");
      chk(N_CELL'(tdo_oe), N_CELL'(1'b0), "tdo enable idle");
      $display("idcode test done");
   endtask : t_idcode

   task automatic t_extest();
      pv = {3{33'h1a5c3e697}};
      ir(IR_SAMPLE);
      u_tap_tester.scan(1'b0, N_CELL, pv, got, oe_all);
      chk(N_CELL'(pad), N_CELL'({core_out & IO_MAP, core_oe & IO_MAP}), "sample pads");
      chk(N_CELL'(core_in), N_CELL'(pin_in), "sample core");
      ir(IR_EXTEST);
      chk(N_CELL'(pad), N_CELL'(pad_of(pv)), "extest drive");
      exp = '0;
      for (int p = 0; p < N_POS; p++)
      begin
         exp[hi[p]] = pin_in[p];
         if (IO_MAP[p])
         begin
            exp[hi[p]-1] = core_out[p];
            exp[hi[p]-2] = core_oe[p];
         end
      end
      u_tap_tester.scan(1'b0, N_CELL, pv, got, oe_all);
      chk(got, exp, "extest capture");
      $display("extest test done");
   endtask : t_extest

   task automatic t_intest();
      ir(IR_INTEST);
      exp = '0;
      for (int p = 0; p < N_POS; p++)
         exp[p] = pv[hi[p]];
      chk(N_CELL'(core_in), exp, "intest apply");
      $display("intest test done");
   endtask : t_intest

   task automatic t_bypass();
      logic [3:0] codes [4];
      codes = '{IR_BYPASS, 4'h9, 4'h6, IR_CLAMP};
      foreach (codes[k])
      begin
         ir(codes[k]);
         u_tap_tester.scan(1'b0, 8, N_CELL'(8'h4d), got, oe_all);
         chk(N_CELL'(got[7:0]), N_CELL'(8'h9a), "one bit path");
      end
      // core drive moves, clamped pads must not
      @(posedge clk);
      core_out <= ~core_out;
      repeat (6) @(posedge clk);
      chk(N_CELL'(pad), N_CELL'(pad_of(pv)), "clamp hold");
      ir(IR_HIGHZ);
      chk(N_CELL'(pad.oe), N_CELL'(1'b0), "highz");
      $display("bypass clamp highz test done");
   endtask : t_bypass

   // =====================================================
   // main sequence and watchdog
   initial
   begin
      int b;
      b = 0;
      for (int p = 0; p < N_POS; p++)
      begin
         hi[p] = N_CELL - 1 - b;
         b = b + (IO_MAP[p] ? 3 : 1);
      end
      arst_n = 1'b0;
      pin_in = 47'h2b6d1c3a95e7;
      core_out = 47'h5e1b7a24c3d9;
      core_oe = 47'h33c6e98b1d52;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_idcode();
      t_extest();
      t_intest();
      t_bypass();
      t_idcode();
      conclude();
   end

   initial
   begin
      #400000;
      error_cnt++;
      $display("wrong value at %0t ns: timeout", $time);
      conclude();
   end

endmodule : boundary_scan_tap_tb
